/* core/pwm_core.sv */
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module pwm_core #(
   parameter int POST_W = 4
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // pwm pin, driven toward the external load
   output logic             pwm_out,
   output logic             pwm_out_oe,
   // postscaled period pulse for a slower update rate
   output logic             post_pulse
);

   // software registers
   logic [7:0]           period_q;
   logic [7:0]           duty_wr_q;
   logic [5:0]           ctrl_q;
   logic [6:0]           tctrl_q;
   // timer, active duty and pin state
   logic [7:0]           timer_q;
   logic [7:0]           duty_ac_q;
   logic [1:0]           duty_lsb_q;
   logic                 pin_q;
   logic                 oe_q;
   logic [POST_W-1:0]    post_cnt_q;
   logic                 post_q;
   logic                 post_flag_q;
   // apb answer registers
   logic [31:0]          prdata_q;
   logic                 pready_q;
   logic                 pslverr_q;

   logic                 pwm_mode;
   logic                 timer_run;
   logic                 tick;
   logic [1:0]           sub_count;
   logic                 match;
   logic                 restart;
   logic [9:0]           duty_next;
   logic                 duty_hit;
   logic                 wr_acc;
   logic                 rd_acc;
   logic                 addr_ok;
   logic [31:0]          rd_mux;

   // mode and enable decode
   always_comb begin
      pwm_mode  = (ctrl_q[pwm_pkg::CTRL_MODE_LSB +: pwm_pkg::CTRL_MODE_W]
                   & pwm_pkg::MODE_PWM_MSB_MASK)
                  == pwm_pkg::MODE_PWM_MSB_MASK;
      timer_run = tctrl_q[pwm_pkg::TCTRL_ON_BIT];
   end

   pwm_prescaler u_pre (
      .pclk      (pclk),
      .presetn   (presetn),
      .run       (timer_run),
      .pre_sel   (tctrl_q[pwm_pkg::TCTRL_PRE_LSB +: 2]),
      .tick      (tick),
      .sub_count (sub_count)
   );

   // period match and restart strobe
   always_comb begin
      match     = (timer_q == period_q);
      restart   = tick && match;
      duty_next = {duty_wr_q,
                   ctrl_q[pwm_pkg::CTRL_DLSB_LSB +: 2]};
      // compare active duty with timer and sub-count
      // a duty beyond the period never hits, so the pin stays high
      duty_hit  = ({duty_ac_q, duty_lsb_q} == {timer_q, sub_count});
   end

   // base timer: counts on prescaled ticks, clears one tick after a match
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_q <= 8'h00;
      end else if (wr_acc && paddr == pwm_pkg::ADDR_TIMER) begin
         timer_q <= pwdata[7:0];
      end else if (tick) begin
         timer_q <= match ? 8'h00 : timer_q + 8'h01;
      end
   end

   // active duty latch, loaded at period restart in pwm mode, or by a write to ADDR_DUTY_AC outside pwm mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_ac_q  <= pwm_pkg::DUTY_RST;
         duty_lsb_q <= 2'h0;
      end else if (restart && pwm_mode) begin
         // hidden 2-bit latch takes the low bits
         duty_ac_q  <= duty_next[9:2];
         duty_lsb_q <= duty_next[1:0];
      end else if (wr_acc && paddr == pwm_pkg::ADDR_DUTY_AC && !pwm_mode) begin
         duty_ac_q <= pwdata[7:0];
      end
   end

   // output latch: set at restart, cleared on duty hit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_q <= 1'b0;
      end else if (ctrl_q == pwm_pkg::CTRL_RST) begin
         // cleared control forces the latch low
         pin_q <= 1'b0;
      end else if (!pwm_mode || !timer_run) begin
         pin_q <= pin_q;
      end else if (restart) begin
         // set unless the new duty is zero
         pin_q <= (duty_next != 10'h000);
      end else if (duty_hit) begin
         pin_q <= 1'b0;
      end
   end

   // the pin is driven only while pwm mode is chosen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= pwm_mode;
      end
   end

   // postscaler counts restarts for a separate update rate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         post_cnt_q <= '0;
         post_q     <= 1'b0;
      end else begin
         post_q <= 1'b0;
         // postscaler sits beside the period path, never in it
         if (tick && match) begin
            if (post_cnt_q >= tctrl_q[pwm_pkg::TCTRL_POST_LSB +: POST_W]) begin
               post_cnt_q <= '0;
               post_q     <= 1'b1;
            end else begin
               post_cnt_q <= post_cnt_q + 1'b1;
            end
         end
      end
   end

   // sticky postscale flag; a new pulse wins over a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         post_flag_q <= 1'b0;
      end else if (post_q) begin
         post_flag_q <= 1'b1;
      end else if (wr_acc && paddr == pwm_pkg::ADDR_STATUS
                   && pwdata[pwm_pkg::STAT_POST_BIT]) begin
         post_flag_q <= 1'b0;
      end
   end

   // apb decode: accept in the first access cycle, answer with ready in the second
   always_comb begin
      wr_acc  = psel && penable && pwrite && !pready_q;
      rd_acc  = psel && penable && !pwrite && !pready_q;
      addr_ok = 1'b1;
      rd_mux  = 32'h0000_0000;
      unique case (paddr)
         pwm_pkg::ADDR_PERIOD:  rd_mux[7:0] = period_q;
         pwm_pkg::ADDR_DUTY_WR: rd_mux[7:0] = duty_wr_q;
         pwm_pkg::ADDR_DUTY_AC: rd_mux[7:0] = duty_ac_q;
         pwm_pkg::ADDR_CTRL:    rd_mux[5:0] = ctrl_q;
         pwm_pkg::ADDR_TCTRL:   rd_mux[6:0] = tctrl_q;
         pwm_pkg::ADDR_TIMER:   rd_mux[7:0] = timer_q;
         pwm_pkg::ADDR_STATUS: begin
            rd_mux[pwm_pkg::STAT_PIN_BIT]  = pin_q;
            rd_mux[pwm_pkg::STAT_POST_BIT] = post_flag_q;
         end
         default:               addr_ok = 1'b0;
      endcase
   end

   // software-written registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_q  <= pwm_pkg::PERIOD_RST;
         duty_wr_q <= pwm_pkg::DUTY_RST;
         ctrl_q    <= pwm_pkg::CTRL_RST;
         tctrl_q   <= pwm_pkg::TCTRL_RST;
      end else if (wr_acc) begin
         // writes land any time; a new duty reaches the output at the next restart
         unique case (paddr)
            pwm_pkg::ADDR_PERIOD:  period_q  <= pwdata[7:0];
            pwm_pkg::ADDR_DUTY_WR: duty_wr_q <= pwdata[7:0];
            pwm_pkg::ADDR_CTRL:    ctrl_q    <= pwdata[pwm_pkg::CTRL_W-1:0];
            pwm_pkg::ADDR_TCTRL:   tctrl_q   <= pwdata[pwm_pkg::TCTRL_W-1:0];
            default:               ;
         endcase
      end
   end

   // apb answer: one-cycle ready, error on unmapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= wr_acc || rd_acc;
         pslverr_q <= (wr_acc || rd_acc) && !addr_ok;
         prdata_q  <= rd_acc ? rd_mux : 32'h0000_0000;
      end
   end

   // resolution follows from timer plus sub-count width
   always_comb begin
      prdata     = prdata_q;
      pready     = pready_q;
      pslverr    = pslverr_q;
      pwm_out    = pin_q;
      pwm_out_oe = oe_q;
      post_pulse = post_q;
   end

endmodule

/* core/pwm_pkg.sv */
package pwm_pkg;

   // register byte offsets on the APB word map
   localparam logic [7:0] ADDR_PERIOD  = 8'h00;
   localparam logic [7:0] ADDR_DUTY_WR = 8'h04;
   localparam logic [7:0] ADDR_DUTY_AC = 8'h08;
   localparam logic [7:0] ADDR_CTRL    = 8'h0C;
   localparam logic [7:0] ADDR_TCTRL   = 8'h10;
   localparam logic [7:0] ADDR_TIMER   = 8'h14;
   localparam logic [7:0] ADDR_STATUS  = 8'h18;

   // control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_MODE_W   = 4;
   localparam int CTRL_DLSB_LSB = 4;
   localparam int CTRL_W        = 6;
   localparam logic [3:0] MODE_PWM_MSB_MASK = 4'hC;

   // timer control register fields
   localparam int TCTRL_PRE_LSB  = 0;
   localparam int TCTRL_ON_BIT   = 2;
   localparam int TCTRL_POST_LSB = 3;
   localparam int TCTRL_W        = 7;

   // prescale selections
   localparam logic [1:0] PRE_DIV1  = 2'h0;
   localparam logic [1:0] PRE_DIV4  = 2'h1;

   // divider end counts: a timer tick every 4, 16 or 64 clocks
   localparam logic [5:0] SPAN_DIV1  = 6'h03;
   localparam logic [5:0] SPAN_DIV4  = 6'h0F;
   localparam logic [5:0] SPAN_DIV16 = 6'h3F;

   // reset values
   localparam logic [7:0] PERIOD_RST = 8'hFF;
   localparam logic [7:0] DUTY_RST   = 8'h00;
   localparam logic [5:0] CTRL_RST   = 6'h00;
   localparam logic [6:0] TCTRL_RST  = 7'h00;

   // last sub-count phase within a timer tick with no prescale
   localparam logic [1:0] PHASE_LAST = 2'h3;

   // status bits
   localparam int STAT_PIN_BIT  = 0;
   localparam int STAT_POST_BIT = 1;

endpackage

/* core/pwm_prescaler.sv */
`timescale 1ns/1ps
// divides the system clock into timer ticks and yields the 2-bit sub-count
module pwm_prescaler (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // control
   input  wire logic       run,
   input  wire logic [1:0] pre_sel,
   // outputs
   output logic            tick,
   output logic [1:0]      sub_count
);

   logic [5:0] div_q;
   logic [5:0] div_d;
   logic [5:0] span;

   // span is ticks length minus one: 4, 16 or 64 phases of the clock
   always_comb begin
      unique case (pre_sel)
         pwm_pkg::PRE_DIV1: span = pwm_pkg::SPAN_DIV1;
         pwm_pkg::PRE_DIV4: span = pwm_pkg::SPAN_DIV4;
         default:           span = pwm_pkg::SPAN_DIV16;
      endcase
      div_d = (div_q >= span) ? 6'h00 : div_q + 6'h01;
   end

   // free count while running; held at zero when stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 6'h00;
      end else if (!run) begin
         div_q <= 6'h00;
      end else begin
         div_q <= div_d;
      end
   end

   // sub-count is the top two bits of the active divider span
   always_comb begin
      unique case (pre_sel)
         pwm_pkg::PRE_DIV1: sub_count = div_q[1:0];
         pwm_pkg::PRE_DIV4: sub_count = div_q[3:2];
         default:           sub_count = div_q[5:4];
      endcase
      tick = run && (div_q >= span);
   end

endmodule

/* tb/pwm_core_bench.sv */
`timescale 1ns/1ps
// random periods and duties, checked by reads and by the load
module pwm_core_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        pwm_out, pwm_out_oe, post_pulse, arm, seen;
   logic [7:0]  paddr, per;
   logic [31:0] pwdata, prdata;
   logic [15:0] hi_len, per_len;
   logic [9:0]  d10;
   int          n_mismatch, samples_checked, cyc, n_post, post_mark;
   logic [31:0] rd_q[$];
   logic [31:0] pw_q[$];
   pwm_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pwm_out(pwm_out), .pwm_out_oe(pwm_out_oe), .post_pulse(post_pulse));
   pwm_load_model i_load (.pclk(pclk), .pwm_out(pwm_out),
      .pwm_out_oe(pwm_out_oe), .arm(arm), .seen(seen), .hi_len(hi_len),
      .per_len(per_len));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task results;
      if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one apb transfer, then an idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   // scoreboard: oldest note against each result; status hides its flag
   always @(posedge pclk) begin
      cyc++;
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk(paddr == pwm_pkg::ADDR_STATUS ? prdata & 32'hFFFFFFFD : prdata,
            rd_q.pop_front(), "prdata");
      if (seen === 1'b1)
         chk({per_len, hi_len}, pw_q.pop_front(), "pwm");
      if (post_pulse === 1'b1) n_post++;
      if (cyc == 20000) begin
         n_mismatch++;
         results();
      end
   end
   initial begin
      {psel, penable, pwrite, arm} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      presetn = 1'b0;
      void'($urandom(26));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(pwm_pkg::ADDR_PERIOD, 32'h000000FF);
      rd(pwm_pkg::ADDR_CTRL, 32'h0);
      rd(8'h1C, 32'h0);
      apb(1'b1, pwm_pkg::ADDR_CTRL, 32'h0000000C);
      for (int i = 0; i < 6; i++) begin
         per = 8'($urandom_range(15, 3));
         // top duty stays below the restart phase so the pin still falls
         d10 = 10'($urandom_range(4 * per + 2, 1));
         apb(1'b1, pwm_pkg::ADDR_TCTRL, {25'h0, 4'($urandom), 3'h4});
         apb(1'b1, pwm_pkg::ADDR_PERIOD, {24'h0, per});
         // restart the count so a smaller period cannot wrap past 255
         apb(1'b1, pwm_pkg::ADDR_TIMER, 32'h0);
         apb(1'b1, pwm_pkg::ADDR_DUTY_WR, {24'h0, d10[9:2]});
         apb(1'b1, pwm_pkg::ADDR_CTRL, {26'h0, d10[1:0], 4'hC});
         apb(1'b1, pwm_pkg::ADDR_DUTY_AC, 32'h000000AA);
         repeat (200) @(posedge pclk);
         rd(pwm_pkg::ADDR_DUTY_AC, {24'h0, d10[9:2]});
         // registered pin drops one clock after the duty equality
         pw_q.push_back({16'(4 * per + 4), 16'(d10) + 16'h0001});
         arm <= 1'b1;
         do @(posedge pclk); while (seen !== 1'b1);
         arm <= 1'b0;
      end
      // zero duty stays low, oversize duty stays high
      apb(1'b1, pwm_pkg::ADDR_TCTRL, 32'h00000004);
      post_mark = n_post;
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, pwm_pkg::ADDR_DUTY_WR, k ? 32'hFF : 32'h0);
         apb(1'b1, pwm_pkg::ADDR_CTRL, k ? 32'h3C : 32'h0C);
         repeat (200) @(posedge pclk);
         repeat (4) rd(pwm_pkg::ADDR_STATUS, k);
      end
      chk(32'(n_post > post_mark), 32'h1, "post_pulse");
      // clearing control while the pin is high
      apb(1'b1, pwm_pkg::ADDR_CTRL, 32'h0);
      rd(pwm_pkg::ADDR_STATUS, 32'h0);
      results();
   end
endmodule

/* tb/pwm_core_monitor.sv */
`timescale 1ns/1ps
// watches the apb answer and the pin of the pwm core
module pwm_core_monitor #(
   parameter int POST_W = 4
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic        pwm_out,
   input  wire logic        pwm_out_oe,
   input  wire logic        post_pulse
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // an access phase not answered yet
   logic acc;
   assign acc = psel && penable && !pready;
   a_ready_next: assert property (acc |=> pready)
      else $error("no ready after access");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_quiet: assert property (pslverr && !pwrite |-> pready && prdata == 0)
      else $error("refused read not quiet");
   // unaligned offsets inside the map are refused as well
   a_err_unmapped: assert property (acc && (paddr > pwm_pkg::ADDR_STATUS
      || paddr[1:0] != 2'h0) |=> pslverr)
      else $error("unmapped access accepted");
   a_err_mapped: assert property (acc && paddr <= pwm_pkg::ADDR_STATUS
      && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("mapped access refused");
   // pin only sets in pwm mode
   a_rise_in_mode: assert property ($rose(pwm_out) |-> pwm_out_oe)
      else $error("pin rose outside pwm mode");
   a_ctrl_clear: assert property (acc && pwrite &&
      paddr == pwm_pkg::ADDR_CTRL && pwdata[5:0] == 6'h00 |-> ##[1:2] !pwm_out)
      else $error("pin high after control cleared");
   a_post_single: assert property (post_pulse |=> !post_pulse)
      else $error("post pulse too long");
endmodule
bind pwm_core pwm_core_monitor #(.POST_W(POST_W)) i_mon (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pwm_out(pwm_out), .pwm_out_oe(pwm_out_oe),
   .post_pulse(post_pulse));

/* tb/pwm_load_model.sv */
`timescale 1ns/1ps
// external load: measures high time and period between rising edges
module pwm_load_model (
   // clock
   input  wire logic        pclk,
   // pin and arming
   input  wire logic        pwm_out,
   input  wire logic        pwm_out_oe,
   input  wire logic        arm,
   // one measurement
   output logic             seen,
   output logic [15:0]      hi_len,
   output logic [15:0]      per_len
);
   logic        pin;
   logic        last;
   logic [1:0]  st;
   logic [15:0] cnt;
   logic [15:0] hc;
   // the load has a pull-down, so an undriven pin reads low
   assign pin = pwm_out_oe ? pwm_out : 1'b0;
   // second rising edge closes one measured period
   always @(posedge pclk) begin
      last <= pin;
      seen <= 1'b0;
      cnt <= cnt + 16'h0001;
      hc <= hc + {15'h0000, pin};
      if (!arm) begin
         st <= 2'h0;
      end else if (pin && !last && st != 2'h2) begin
         seen <= (st == 2'h1);
         hi_len <= hc;
         per_len <= cnt;
         st <= st + 2'h1;
         cnt <= 16'h0001;
         hc <= 16'h0001;
      end
   end
endmodule
